/* File: logic/dif_params.svh */
// constants for the dock interrupt forwarding block
`ifndef DIF_PARAMS_SVH
`define DIF_PARAMS_SVH
`define DIF_REG_SIRQ_CTRL      8'h4e
`define DIF_REG_SIRQ_STATE     8'h4f
`define DIF_REG_ROUTE          8'h48
`define DIF_REG_DB_ADDR0       8'h54
`define DIF_REG_DB_ADDR1       8'h55
`define DIF_REG_DB_ADDR2       8'h56
`define DIF_REG_DB_ADDR3       8'h57
`define DIF_REG_SMI_EN         8'h49
`define DIF_REG_EVENT          8'h60
`define DIF_REG_SLOT_DATA0     8'h58
`define DIF_REG_SLOT_DATA1     8'h59
`define DIF_REG_SLOT_DATA2     8'h5a
`define DIF_BIT_ENABLE         0
`define DIF_BIT_START_LO       2
`define DIF_BIT_SLOTS21        4
`define DIF_BIT_QUIET          6
`define DIF_BIT_HALT           7
`define DIF_CTRL_RESET         8'h00
`define DIF_ROUTE_RESET        8'he4
`define DIF_DB_ADDR_RESET      32'h33333330
`define DIF_STOP_CONT          3
`define DIF_STOP_QUIET         2
`define DIF_SLOTS_SHORT        17
`define DIF_SLOTS_LONG         21
`define DIF_SLOT_CLKS          3
`define DIF_START_W0           4
`define DIF_START_W1           6
`define DIF_START_W2           8
`endif

/* File: logic/dif_pkg.sv */
// types shared by both ends of the dock interrupt forwarding link
package dif_pkg;
    typedef enum logic [2:0] {
        DIF_IDLE  = 3'b000,
        DIF_START = 3'b001,
        DIF_DATA  = 3'b011,
        DIF_STOP  = 3'b010,
        DIF_HALT  = 3'b110,
        DIF_QIDLE = 3'b111
    } dif_sirq_state_t;
    typedef logic [7:0]  dif_byte_t;
    typedef logic [31:0] dif_word_t;
endpackage

/* File: logic/dif_link_if.sv */
// link between the bridge end and the host end
`timescale 1ns/1ps
`default_nettype none
interface dif_link_if;
    logic        sirq_o_dev;        // bridge drives serial_int_line low-active data
    logic        sirq_oe_dev;
    logic        sirq_o_per;        // peripheral side drive
    logic        sirq_oe_per;
    logic        serial_int_line;   // resolved wire level, pulled high
    logic [3:0]  host_int_lines;    // active high inside the chip
    logic        db_req;            // driveback bus request
    logic        db_gnt;
    logic        db_wr;             // one-cycle driveback write
    logic [31:0] db_addr;
    logic [31:0] db_data;
    logic        clk_stop_req;      // power manager asks to stop the clock
    assign serial_int_line = (sirq_oe_dev ? sirq_o_dev : 1'b1)
                           & (sirq_oe_per ? sirq_o_per : 1'b1);
    modport dev (output sirq_o_dev, output sirq_oe_dev, input serial_int_line,
                 output host_int_lines, output db_req, input db_gnt, output db_wr,
                 output db_addr, output db_data, input clk_stop_req);
    modport host (output sirq_o_per, output sirq_oe_per, input serial_int_line,
                  input host_int_lines, input db_req, output db_gnt, input db_wr,
                  input db_addr, input db_data, output clk_stop_req);
endinterface
`default_nettype wire

/* File: logic/dif_bridge.sv */
// bridge end: pci interrupt routing, driveback and serial irq controller
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dif_params.svh"
module dif_bridge (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [7:0]       reg_addr_i,
    input  wire dif_pkg::dif_byte_t reg_wdata_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    output dif_pkg::dif_byte_t    reg_rdata_o,
    input  wire logic [3:0]       dock_int_i,
    input  wire logic             status_event_i,
    input  wire logic             other_req_i,
    output logic                  other_gnt_o,
    output logic                  status_irq_o,
    output logic [23:0]           sirq_slots_o,
    dif_link_if.dev               link
);
    import dif_pkg::*;

    dif_byte_t        ctrl_r, route_r, smi_en_r;
    dif_word_t        db_addr_r;
    logic [3:0]       event_r;
    dif_sirq_state_t  st_r;
    logic [4:0]       cnt_r;
    logic [1:0]       phase_r;
    logic [23:0]      slots_r;
    logic             line_s;
    logic             quiet_r;
    logic             stop_cont_r;
    logic [3:0]       fwd_r;
    logic             db_pend_r, db_busy_r;

    ////////////////////////////////////////////////////////////////////////
    // both ends drive the line from flops on this clock, so it is read directly;
    // a two-sample filter would swallow the one-clock slot pulses
    assign line_s = link.serial_int_line;

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r    <= `DIF_CTRL_RESET;
            route_r   <= `DIF_ROUTE_RESET;
            smi_en_r  <= 8'h00;
            db_addr_r <= `DIF_DB_ADDR_RESET;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `DIF_REG_SIRQ_CTRL: ctrl_r          <= reg_wdata_i;
                `DIF_REG_ROUTE:     route_r         <= reg_wdata_i;
                `DIF_REG_SMI_EN:    smi_en_r        <= reg_wdata_i;
                `DIF_REG_DB_ADDR0:  db_addr_r[7:0]  <= reg_wdata_i;
                `DIF_REG_DB_ADDR1:  db_addr_r[15:8] <= reg_wdata_i;
                `DIF_REG_DB_ADDR2:  db_addr_r[23:16] <= reg_wdata_i;
                `DIF_REG_DB_ADDR3:  db_addr_r[31:24] <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // status events: set wins over the write-back clear
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            event_r <= 4'h0;
        end else begin
            event_r <= (event_r & ~((reg_wr_i && reg_addr_i == `DIF_REG_EVENT)
                        ? reg_wdata_i[3:0] : 4'h0))
                       | {3'b000, status_event_i};
        end
    end
    assign status_irq_o = |event_r;

    // read data one cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `DIF_REG_SIRQ_CTRL:  reg_rdata_o <= ctrl_r;
                `DIF_REG_SIRQ_STATE: reg_rdata_o <= {st_r == DIF_HALT,
                                                     quiet_r, 6'h00};
                `DIF_REG_ROUTE:      reg_rdata_o <= route_r;
                `DIF_REG_SMI_EN:     reg_rdata_o <= smi_en_r;
                `DIF_REG_DB_ADDR0:   reg_rdata_o <= db_addr_r[7:0];
                `DIF_REG_DB_ADDR1:   reg_rdata_o <= db_addr_r[15:8];
                `DIF_REG_DB_ADDR2:   reg_rdata_o <= db_addr_r[23:16];
                `DIF_REG_DB_ADDR3:   reg_rdata_o <= db_addr_r[31:24];
                `DIF_REG_EVENT:      reg_rdata_o <= {4'h0, event_r};
                `DIF_REG_SLOT_DATA0: reg_rdata_o <= slots_r[7:0];
                `DIF_REG_SLOT_DATA1: reg_rdata_o <= slots_r[15:8];
                `DIF_REG_SLOT_DATA2: reg_rdata_o <= slots_r[23:16];
                default:             reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial irq controller
    logic [4:0] start_len, slot_cnt;
    always_comb begin
        case (ctrl_r[`DIF_BIT_START_LO +: 2])
            2'b00:   start_len = 5'(`DIF_START_W0);
            2'b01:   start_len = 5'(`DIF_START_W1);
            default: start_len = 5'(`DIF_START_W2);           // reserved treated as 8
        endcase
        slot_cnt = ctrl_r[`DIF_BIT_SLOTS21] ? 5'(`DIF_SLOTS_LONG)
                                            : 5'(`DIF_SLOTS_SHORT);
    end
    wire enable = ctrl_r[`DIF_BIT_ENABLE];

    // runs once enabled; a new frame leaves idle only while no clock-stop request is pending
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r        <= DIF_IDLE;
            cnt_r       <= 5'd0;
            phase_r     <= 2'd0;
            quiet_r     <= 1'b0;
            stop_cont_r <= 1'b1;
            slots_r     <= 24'h0;
        end else if (!enable) begin
            st_r    <= DIF_IDLE;
            quiet_r <= 1'b0;
            cnt_r   <= 5'd0;
        end else begin
            case (st_r)
                DIF_IDLE: begin
                    // start only when no clock-stop request pending
                    if (!link.clk_stop_req) begin
                        st_r  <= DIF_START;
                        cnt_r <= 5'd0;
                    end
                end
                DIF_QIDLE: begin
                    if (!line_s) begin
                        st_r    <= DIF_START;
                        cnt_r   <= 5'd1;
                        quiet_r <= 1'b0;
                    end
                end
                DIF_START: begin
                    if (cnt_r == start_len + 5'd1) begin    // pulse plus turnaround
                        st_r    <= DIF_DATA;
                        cnt_r   <= 5'd0;
                        phase_r <= 2'd0;
                    end else begin
                        cnt_r <= cnt_r + 5'd1;
                    end
                end
                DIF_DATA: begin
                    // sample phase of each slot
                    if (phase_r == 2'd0) begin
                        slots_r[cnt_r] <= ~line_s;
                    end
                    if (phase_r == 2'(`DIF_SLOT_CLKS - 1)) begin
                        phase_r <= 2'd0;
                        if (cnt_r == slot_cnt - 5'd1) begin
                            // frame end: sample mode requests
                            st_r        <= DIF_STOP;
                            cnt_r       <= 5'd0;
                            stop_cont_r <= ctrl_r[`DIF_BIT_HALT]
                                         | ~ctrl_r[`DIF_BIT_QUIET];
                            quiet_r     <= ctrl_r[`DIF_BIT_QUIET]
                                         & ~ctrl_r[`DIF_BIT_HALT];
                        end else begin
                            cnt_r <= cnt_r + 5'd1;
                        end
                    end else begin
                        phase_r <= phase_r + 2'd1;
                    end
                end
                DIF_STOP: begin
                    // stop pulse 3 clocks continuous, 2 quiet
                    if (cnt_r == (stop_cont_r ? 5'(`DIF_STOP_CONT)
                                              : 5'(`DIF_STOP_QUIET))) begin
                        cnt_r <= 5'd0;
                        if (ctrl_r[`DIF_BIT_HALT]) begin
                            st_r <= DIF_HALT;
                        end else if (quiet_r) begin
                            st_r <= DIF_QIDLE;
                        end else begin
                            st_r <= DIF_IDLE;
                        end
                    end else begin
                        cnt_r <= cnt_r + 5'd1;
                    end
                end
                DIF_HALT: begin
                    if (!ctrl_r[`DIF_BIT_HALT]) begin
                        st_r    <= DIF_START;
                        cnt_r   <= 5'd0;
                        quiet_r <= 1'b0;
                    end
                end
                default: st_r <= DIF_IDLE;
            endcase
        end
    end

    // drive low during pulses, high for one clock after
    always_comb begin
        link.sirq_o_dev  = 1'b1;
        link.sirq_oe_dev = 1'b0;
        if (st_r == DIF_START && cnt_r <= start_len) begin
            link.sirq_oe_dev = 1'b1;
            link.sirq_o_dev  = (cnt_r == start_len);
        end else if (st_r == DIF_STOP) begin
            link.sirq_oe_dev = 1'b1;
            link.sirq_o_dev  = (cnt_r == (stop_cont_r ? 5'(`DIF_STOP_CONT)
                                                      : 5'(`DIF_STOP_QUIET)));
        end
    end
    assign sirq_slots_o = slots_r;

    ////////////////////////////////////////////////////////////////////////
    // routing of dock lines onto host lines
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_route
            always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    fwd_r[g] <= 1'b0;
                end else begin
                    fwd_r[g] <= |(dock_int_i & {route_r[7:6] == 2'(g),
                                  route_r[5:4] == 2'(g), route_r[3:2] == 2'(g),
                                  route_r[1:0] == 2'(g)});
                end
            end
        end
    endgenerate
    assign link.host_int_lines = fwd_r;

    ////////////////////////////////////////////////////////////////////////
    // driveback request and write; highest priority
    logic [3:0] fwd_d_r;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fwd_d_r   <= 4'h0;
            db_pend_r <= 1'b0;
            db_busy_r <= 1'b0;
            link.db_wr   <= 1'b0;
            link.db_addr <= 32'h0;
            link.db_data <= 32'h0;
        end else begin
            fwd_d_r    <= fwd_r;
            link.db_wr <= 1'b0;
            if (link.db_req && link.db_gnt) begin
                link.db_wr   <= 1'b1;
                link.db_addr <= db_addr_r;
                link.db_data <= {8'h00, slots_r[23:4], fwd_r};
                db_busy_r    <= 1'b0;
            end
            if ((fwd_r != fwd_d_r) || (|(smi_en_r[3:0] & event_r))) begin
                db_pend_r <= 1'b1;
            end else if (db_pend_r && !db_busy_r) begin
                db_pend_r <= 1'b0;
                db_busy_r <= 1'b1;
            end
        end
    end
    assign link.db_req = db_busy_r;
    assign other_gnt_o = other_req_i & ~db_busy_r & ~db_pend_r;
endmodule
`default_nettype wire

/* File: logic/dif_host.sv */
// host end: serial irq peripheral and host pci grant/capture
`timescale 1ns/1ps
`default_nettype none
`include "dif_params.svh"
module dif_host (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [23:0]  irq_req_i,
    input  wire logic         clk_stop_i,
    output logic [3:0]        host_int_o,
    output logic              db_seen_o,
    output dif_pkg::dif_word_t db_addr_o,
    output dif_pkg::dif_word_t db_data_o,
    dif_link_if.host          link
);
    import dif_pkg::*;

    logic       line_s, line_d_r;
    logic [5:0] low_cnt_r;
    logic [1:0] phase_r;
    logic [4:0] slot_r;
    logic       in_frame_r, drv_r, hi_r;

    ////////////////////////////////////////////////////////////////////////
    // same clock as the bridge, read directly; previous level kept for edges
    assign line_s = link.serial_int_line;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            line_d_r <= 1'b1;
        end else begin
            line_d_r <= line_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame tracker: long low is a start, then three clocks per slot
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_cnt_r  <= 6'd0;
            phase_r    <= 2'd0;
            slot_r     <= 5'd0;
            in_frame_r <= 1'b0;
            drv_r      <= 1'b0;
            hi_r       <= 1'b0;
        end else begin
            low_cnt_r <= line_s ? 6'd0 : low_cnt_r + 6'd1;
            hi_r      <= drv_r;
            drv_r     <= 1'b0;
            if (line_s && !line_d_r && low_cnt_r >= 6'(`DIF_START_W0)) begin
                in_frame_r <= 1'b1;
                phase_r    <= 2'd0;
                slot_r     <= 5'd0;
            end else if (in_frame_r) begin
                // low on the bridge's sampling clock, high the clock after
                if (phase_r == 2'd0 && slot_r < 5'(`DIF_SLOTS_LONG)) begin
                    drv_r <= irq_req_i[slot_r];
                end
                if (phase_r == 2'(`DIF_SLOT_CLKS - 1)) begin
                    phase_r <= 2'd0;
                    slot_r  <= slot_r + 5'd1;
                end else begin
                    phase_r <= phase_r + 2'd1;
                end
                // two lows in a row not of our making are the stop pulse
                if (!line_s && low_cnt_r >= 6'(`DIF_STOP_QUIET - 1)
                    && !drv_r && !hi_r) begin
                    in_frame_r <= 1'b0;
                end
            end else if (!line_s) begin
                in_frame_r <= 1'b0;
            end
        end
    end
    assign link.sirq_o_per  = ~drv_r;
    assign link.sirq_oe_per = drv_r | hi_r;
    assign link.clk_stop_req = clk_stop_i;
    assign host_int_o = link.host_int_lines;

    ////////////////////////////////////////////////////////////////////////
    // grant driveback and capture the write
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link.db_gnt <= 1'b0;
            db_seen_o   <= 1'b0;
            db_addr_o   <= 32'h0;
            db_data_o   <= 32'h0;
        end else begin
            link.db_gnt <= link.db_req & ~link.db_gnt;
            db_seen_o   <= link.db_wr;
            if (link.db_wr) begin
                db_addr_o <= link.db_addr;
                db_data_o <= link.db_data;
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/dif_link_checker.sv */
// assertions on the link between the bridge end and the host end
`timescale 1ns/1ps
`default_nettype none
module dif_link_checker #(
    parameter logic [31:0] DB_ADDR = 32'h33333330
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        sirq_o_dev,
    input  wire logic        sirq_oe_dev,
    input  wire logic        db_req,
    input  wire logic        db_gnt,
    input  wire logic        db_wr,
    input  wire logic [31:0] db_addr,
    input  wire logic [31:0] db_data
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic       dev_low;
    logic [3:0] run_r;
    assign dev_low = sirq_oe_dev && !sirq_o_dev;
    // length of the present low drive; saturates so a stuck line cannot wrap
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) run_r <= 4'h0;
        else if (!dev_low) run_r <= 4'h0;
        else if (run_r != 4'hf) run_r <= run_r + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    pulse_length_a: assert property ($fell(dev_low) |-> run_r inside {2, 3, 4, 6, 8})
        else $error("serial line low drive of illegal length");
    release_high_a: assert property ($fell(sirq_oe_dev) |-> $past(sirq_o_dev))
        else $error("serial line released without a high cycle");
    grant_then_write_a: assert property (db_gnt |=> db_wr)
        else $error("driveback grant not followed by write");
    write_after_grant_a: assert property (db_wr |-> $past(db_gnt))
        else $error("driveback write without grant");
    write_one_cycle_a: assert property (db_wr |=> !db_wr)
        else $error("driveback write longer than one cycle");
    write_address_a: assert property (db_wr |-> db_addr == DB_ADDR)
        else $error("driveback write to wrong address");
    write_upper_zero_a: assert property (db_wr |-> db_data[31:24] == 8'h00)
        else $error("driveback data upper byte not zero");
    request_granted_a: assert property ($rose(db_req) |-> ##[1:2] db_gnt)
        else $error("driveback request not granted in time");
    // main scenarios
    cover property (db_wr);
    cover property ($fell(dev_low) && run_r == 4'h8);
    cover property ($fell(dev_low) && run_r == 4'h3);
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the bridge and host ends joined by the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dif_pkg::*;
    logic        ref_clk, rst_b, reg_wr, reg_rd, status_event, other_gnt, status_irq;
    logic [7:0]  reg_addr;
    dif_byte_t   reg_wdata, reg_rdata;
    logic [3:0]  dock_int, host_int;
    logic [23:0] irq_req, sirq_slots;
    logic        clk_stop, db_seen;
    dif_word_t   db_addr, db_data;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          n;
    dif_link_if link ();
    dif_bridge i_dif_bridge (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .dock_int_i(dock_int), .status_event_i(status_event), .other_req_i(1'b1),
        .other_gnt_o(other_gnt), .status_irq_o(status_irq), .sirq_slots_o(sirq_slots),
        .link(link.dev));
    dif_host i_dif_host (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .irq_req_i(irq_req),
        .clk_stop_i(clk_stop), .host_int_o(host_int), .db_seen_o(db_seen),
        .db_addr_o(db_addr), .db_data_o(db_data), .link(link.host));
    dif_link_checker i_dif_link_checker (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
        .sirq_o_dev(link.sirq_o_dev), .sirq_oe_dev(link.sirq_oe_dev), .db_req(link.db_req),
        .db_gnt(link.db_gnt), .db_wr(link.db_wr), .db_addr(link.db_addr),
        .db_data(link.db_data));
    ////////////////////////////////////////////////////////////////////////////////
    // compare and count; unknowns never match
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // register write: one strobe cycle
    task automatic wr(input logic [7:0] a, input dif_byte_t d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // register read: data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input dif_byte_t exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check($sformatf("register %h", a), {24'h0, reg_rdata}, {24'h0, exp});
    endtask
    // bounded wait for a driveback, then check what it carried
    task automatic wait_db(input logic [3:0] lines);
        n = 0;
        #1;
        while (db_seen !== 1'b1 && n < 30) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (link.db_req === 1'b1) check("other grant", {31'h0, other_gnt}, 0);
        end
        check("driveback seen", {31'h0, db_seen}, 1);
        check("other grant idle", {31'h0, other_gnt}, 1);
        check("driveback address", db_addr, 32'h33333330);
        check("driveback lines", {28'h0, db_data[3:0]}, {28'h0, lines});
        check("host lines", {28'h0, host_int}, {28'h0, lines});
    endtask
    // length of the next low drive by the bridge; late start costs a cycle, hence #1
    task automatic low_run(output int len);
        len = 0;
        n = 0;
        #1;
        while (!(link.sirq_oe_dev && !link.sirq_o_dev) && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        while (link.sirq_oe_dev === 1'b1 && link.sirq_o_dev === 1'b0 && len < 20) begin
            @(posedge ref_clk);
            #1;
            len++;
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // watchdog well beyond the few thousand cycles the sequence needs
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end
    initial begin : main
        int len;
        {rst_b, reg_wr, reg_rd, status_event, clk_stop} = 5'h00;
        {reg_addr, reg_wdata, dock_int} = 20'h00000;
        irq_req = 24'h100a02; // slot 20 only reaches the bridge with 21 slots
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(8'h4e, 8'h00);
        rd(8'h4f, 8'h00);
        rd(8'h48, 8'he4);
        for (int i = 0; i < 4; i++) rd(8'(8'h54 + i), i == 0 ? 8'h30 : 8'h33);
        rd(8'h20, 8'h00);
        check("host lines at reset", {28'h0, host_int}, 0);
        // reversed routing: dock line i lands on host line 3-i
        wr(8'h48, 8'h1b);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            dock_int <= 4'h1 << i;
            wait_db(4'h8 >> i);
        end
        @(posedge ref_clk);
        status_event <= 1'b1;
        @(posedge ref_clk);
        status_event <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("status irq set", {31'h0, status_irq}, 1);
        rd(8'h60, 8'h01);
        wr(8'h60, 8'h01);
        repeat (2) @(posedge ref_clk);
        #1;
        check("status irq cleared", {31'h0, status_irq}, 0);
        wr(8'h4e, 8'h01);
        low_run(len);
        check("first start width", len, 4);
        repeat (300) @(posedge ref_clk);
        #1;
        check("slots of 17", {8'h0, sirq_slots}, 32'h000a02);
        rd(8'h59, 8'h0a);
        @(posedge ref_clk);
        clk_stop <= 1'b1;
        repeat (150) @(posedge ref_clk);
        len = 0;
        repeat (100) begin
            @(posedge ref_clk);
            #1;
            if (link.sirq_oe_dev === 1'b1) len++;
        end
        check("idle under clock stop", len, 0);
        @(posedge ref_clk);
        clk_stop <= 1'b0;
        low_run(len);
        check("start after clock stop", len, 4);
        wr(8'h4e, 8'h81);
        repeat (150) @(posedge ref_clk);
        rd(8'h4f, 8'h80);
        // every width code, reserved one too, each changed while halted
        for (int w = 0; w < 4; w++) begin
            wr(8'h4e, 8'h91 | 8'(w << 2));
            wr(8'h4e, 8'h11 | 8'(w << 2));
            low_run(len);
            check("start width", len, w == 0 ? 4 : w == 1 ? 6 : 8);
            wr(8'h4e, 8'h91 | 8'(w << 2));
            repeat (150) @(posedge ref_clk);
        end
        wr(8'h4e, 8'h1d);
        repeat (300) @(posedge ref_clk);
        #1;
        check("slots of 21", {8'h0, sirq_slots}, 32'h100a02);
        rd(8'h5a, 8'h10);
        wr(8'h4e, 8'h5d); // quiet only; slot count and width stay while running
        repeat (150) @(posedge ref_clk);
        rd(8'h4f, 8'h40);
        print_verdict();
    end
endmodule
`default_nettype wire
